/* rtl/wdt_counter.sv */
// wdt_counter: oscillator-cycle counter producing one time-out pulse per period
`timescale 1ns/1ps

module wdt_counter (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic osc_tick,
    input wire logic restart,
    input wire logic [3:0] presc_sel,
    output logic timeout
);
    import wdt_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic to;
    } wdt_cnt_state_t;

    wdt_cnt_state_t s;
    wdt_cnt_state_t next_s;
    logic [CNT_W-1:0] limit;

    assign limit = timeout_limit(presc_sel);

    always_comb begin
        next_s = s;
        next_s.to = 1'b0;
        if (restart) begin
            next_s.cnt = '0;
        end else if (osc_tick) begin
            // a shorter period may already be passed: fire at once
            if (s.cnt >= limit - 21'h000001) begin
                next_s.cnt = '0;
                next_s.to = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 21'h000001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign timeout = s.to;

endmodule // wdt_counter

/* rtl/wdt_ctrl.sv */
// wdt_ctrl: watchdog control/status registers, modes, timed change sequence
//
// Summary of operation
// - time-out in interrupt mode sets flag bit 7
// - executing watchdog vector clears the flag
// - writing one to flag clears it
// - request needs flag, enable bit 6, global enable
// - enable set, reset enable clear: interrupt only
// - combined mode: first time-out sets flag
// - combined vector clears enable and flag
// - combined: unserviced flag at time-out resets
// - change enable self-clears four cycles later
// - protected changes only while change enable
// - watchdog reset flag forces reset enable
// - prescaler gives 2048 to 1048576 cycles
// - always-on fuse forces reset-only mode
// - watchdog reset sets watchdog reset flag
// - counts oscillator cycles, restart clears counter
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps

module wdt_ctrl (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [wdt_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [wdt_pkg::BE_W-1:0] avs_byteenable,
    input wire logic [wdt_pkg::DATA_W-1:0] avs_writedata,
    output logic [wdt_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic osc_tick,
    input wire logic always_on_fuse,
    input wire logic global_irq_enable,
    input wire logic irq_vector_taken,
    output logic timeout_irq,
    output logic system_reset_req,
    output logic timeout_irq_flag,
    output logic system_reset_enable
);
    import wdt_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic ack;
        logic [DATA_W-1:0] rdata;
        logic irq_flag;
        logic irq_en;
        logic change_en;
        logic [CE_CNT_W-1:0] ce_cnt;
        logic reset_en;
        logic [3:0] presc;
        logic wdt_reset_flag;
        logic rst_pulse;
        logic restart;
    } wdt_state_t;

    wdt_state_t s;
    wdt_state_t next_s;

    logic req;
    logic wr_fire;
    logic [7:0] wbyte;
    logic timeout;
    logic reset_mode;
    logic irq_mode;
    logic combined;

    // ****************************************************************
    // oscillator counter
    // ****************************************************************
    // restart is one clock wide and wins over a tick in the same cycle
    wdt_counter u_counter (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .osc_tick(osc_tick),
        .restart(s.restart),
        .presc_sel(s.presc),
        .timeout(timeout)
    );

    // ****************************************************************
    // mode decode
    // ****************************************************************
    assign req = avs_read | avs_write;
    assign wr_fire = avs_write & s.ack & avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];

    assign combined = !always_on_fuse && s.reset_en && s.irq_en;
    // reset only when enable bit set alone
    assign reset_mode = always_on_fuse || (s.reset_en && !s.irq_en);
    // interrupt only with reset enable clear
    assign irq_mode = !always_on_fuse && !s.reset_en && s.irq_en;

    function automatic logic [7:0] control_byte(input wdt_state_t st);
        logic [7:0] b;
        b = 8'h00;
        b[BIT_IRQ_FLAG] = st.irq_flag;
        b[BIT_IRQ_EN] = st.irq_en;
        b[BIT_PRESC3] = st.presc[3];
        b[BIT_CHANGE_EN] = st.change_en;
        b[BIT_RESET_EN] = st.reset_en;
        b[BIT_PRESC2:BIT_PRESC0] = st.presc[2:0];
        return b;
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_s = s;
        next_s.rst_pulse = 1'b0;
        next_s.restart = 1'b0;

        // one wait cycle, then the answer
        next_s.ack = req & !s.ack;
        if (req && !s.ack && avs_read) begin
            case (avs_address)
                OFS_CONTROL_STATUS: begin
                    next_s.rdata = {24'h000000, control_byte(s)};
                end
                OFS_RESET_CAUSE: begin
                    next_s.rdata = '0;
                    next_s.rdata[BIT_WDT_RESET_FLAG] = s.wdt_reset_flag;
                end
                default: begin
                    next_s.rdata = '0;
                end
            endcase
        end

        // change enable expires after four cycles
        if (s.change_en) begin
            if (s.ce_cnt == CHANGE_EN_CYCLES - 3'h1) begin
                next_s.change_en = 1'b0;
                next_s.ce_cnt = '0;
            end else begin
                next_s.ce_cnt = s.ce_cnt + 3'h1;
            end
        end

        if (wr_fire) begin
            case (avs_address)
                OFS_CONTROL_STATUS: begin
                    if (wbyte[BIT_IRQ_FLAG]) begin
                        next_s.irq_flag = 1'b0;
                    end
                    next_s.irq_en = wbyte[BIT_IRQ_EN];
                    // opening write of the timed sequence
                    if (wbyte[BIT_CHANGE_EN] && wbyte[BIT_RESET_EN]) begin
                        next_s.change_en = 1'b1;
                        next_s.ce_cnt = '0;
                        next_s.reset_en = 1'b1;
                        if (s.change_en) begin
                            next_s.presc = presc_of(wbyte);
                        end
                    // protected bits only inside the window
                    end else if (s.change_en) begin
                        next_s.reset_en = wbyte[BIT_RESET_EN];
                        next_s.presc = presc_of(wbyte);
                        next_s.change_en = 1'b0;
                        next_s.ce_cnt = '0;
                    end else begin
                        // setting the reset enable is never protected
                        next_s.reset_en = s.reset_en | wbyte[BIT_RESET_EN];
                    end
                end
                OFS_RESET_CAUSE: begin
                    if (!wbyte[BIT_WDT_RESET_FLAG]) begin
                        next_s.wdt_reset_flag = 1'b0;
                    end
                end
                OFS_RESTART: begin
                    if (wbyte[BIT_RESTART]) begin
                        next_s.restart = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        if (irq_vector_taken) begin
            next_s.irq_flag = 1'b0;
            if (combined) begin
                next_s.irq_en = 1'b0;
            end
        end

        // time-out handling follows the write and vector clears so a set beats any clear
        if (timeout) begin
            if (reset_mode) begin
                next_s.rst_pulse = 1'b1;
            end else if (combined) begin
                if (s.irq_flag) begin
                    next_s.rst_pulse = 1'b1;
                end else begin
                    next_s.irq_flag = 1'b1;
                end
            end else if (irq_mode) begin
                next_s.irq_flag = 1'b1;
            end
        end

        // the watchdog reset reinitialises flag, enable, prescaler and change enable, sets reset flag
        if (next_s.rst_pulse) begin
            next_s.irq_flag = RST_IRQ_FLAG;
            next_s.irq_en = RST_IRQ_EN;
            next_s.presc = RST_PRESC;
            next_s.change_en = 1'b0;
            next_s.ce_cnt = '0;
            next_s.restart = 1'b1;
            next_s.wdt_reset_flag = 1'b1;
        end

        // reset flag pins the reset enable
        if (next_s.wdt_reset_flag) begin
            next_s.reset_en = 1'b1;
        end
        if (always_on_fuse) begin
            next_s.reset_en = 1'b1;
            next_s.irq_en = 1'b0;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s.ack <= 1'b0;
            s.rdata <= '0;
            s.irq_flag <= RST_IRQ_FLAG;
            s.irq_en <= RST_IRQ_EN;
            s.change_en <= 1'b0;
            s.ce_cnt <= '0;
            s.reset_en <= RST_RESET_EN;
            s.presc <= RST_PRESC;
            s.wdt_reset_flag <= RST_WDT_RESET_FLAG;
            s.rst_pulse <= 1'b0;
            s.restart <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign avs_waitrequest = req & !s.ack;
    assign avs_readdata = s.rdata;
    assign timeout_irq = s.irq_flag & s.irq_en & global_irq_enable;
    assign system_reset_req = s.rst_pulse;
    assign timeout_irq_flag = s.irq_flag;
    assign system_reset_enable = s.reset_en;

endmodule // wdt_ctrl

/* rtl/wdt_pkg.sv */
// wdt_pkg: register map, field positions and timing counts of the watchdog block
package wdt_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFS_CONTROL_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_RESTART = 4'h8;

    // ****************************************************************
    // control/status, reset-cause and restart field positions
    // ****************************************************************
    localparam int BIT_IRQ_FLAG = 7;
    localparam int BIT_IRQ_EN = 6;
    localparam int BIT_PRESC3 = 5;
    localparam int BIT_CHANGE_EN = 4;
    localparam int BIT_RESET_EN = 3;
    localparam int BIT_PRESC2 = 2;
    localparam int BIT_PRESC0 = 0;
    localparam int BIT_WDT_RESET_FLAG = 3;
    localparam int BIT_RESTART = 0;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic RST_IRQ_FLAG = 1'b0;
    localparam logic RST_IRQ_EN = 1'b0;
    localparam logic RST_RESET_EN = 1'b0;
    localparam logic [3:0] RST_PRESC = 4'h0;
    localparam logic RST_WDT_RESET_FLAG = 1'b0;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CE_CNT_W = 3;
    localparam logic [CE_CNT_W-1:0] CHANGE_EN_CYCLES = 3'h4;
    localparam int CNT_W = 21;
    localparam logic [CNT_W-1:0] BASE_TIMEOUT = 21'h000800;
    localparam logic [3:0] PRESC_MAX = 4'h9;

    // oscillator cycles per time-out; reserved codes clamp to the longest
    function automatic logic [CNT_W-1:0] timeout_limit(input logic [3:0] sel);
        logic [3:0] s;
        s = (sel > PRESC_MAX) ? PRESC_MAX : sel;
        return BASE_TIMEOUT << s;
    endfunction

    // prescaler code from the split field of a control byte
    function automatic logic [3:0] presc_of(input logic [7:0] b);
        return {b[BIT_PRESC3], b[BIT_PRESC2:BIT_PRESC0]};
    endfunction

endpackage

/* testbench/tb.sv */
// tb: register-level test of the watchdog control block
`timescale 1ns/1ps
module tb;
    import wdt_pkg::*;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [ADDR_W-1:0] avs_address = 4'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [BE_W-1:0] avs_byteenable = 4'hF;
    logic [DATA_W-1:0] avs_writedata = 32'h0;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic osc_tick = 1'h1;
    logic always_on_fuse = 1'h0;
    logic global_irq_enable = 1'h0;
    logic irq_vector_taken = 1'h0;
    logic timeout_irq;
    logic system_reset_req;
    logic timeout_irq_flag;
    logic system_reset_enable;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0;
    int sel;
    logic [DATA_W-1:0] q;
    logic seen;
    wdt_ctrl wdt_ctrl_i (.*);
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input logic [31:0] sv, input logic [31:0] ev);
        n_checks++;
        if (sv !== ev) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, sv, ev);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // hold the request until waitrequest is sampled low
    task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int i;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'h0) break;
        end
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        if (i == 20) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        acc(1'h0, a, 8'h0);
        check(q, {24'h0, e});
    endtask
    task automatic wait_for(input logic rst_req);
        int i;
        for (i = 0; i < 6000; i++) begin
            @(posedge ref_clk);
            if ((rst_req ? system_reset_req : timeout_irq_flag) === 1'h1) break;
        end
        if (i == 6000) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic vector();
        irq_vector_taken <= 1'h1;
        @(posedge ref_clk);
        irq_vector_taken <= 1'h0;
    endtask
    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'h1;
        rd(OFS_CONTROL_STATUS, 8'h00);
        rd(OFS_RESET_CAUSE, 8'h00);
        rd(4'hC, 8'h00);
        avs_byteenable <= 4'hE;
        acc(1'h1, OFS_CONTROL_STATUS, 8'h40);
        avs_byteenable <= 4'hF;
        rd(OFS_CONTROL_STATUS, 8'h00);
        acc(1'h1, OFS_CONTROL_STATUS, 8'h08);
        acc(1'h1, OFS_CONTROL_STATUS, 8'h21);
        rd(OFS_CONTROL_STATUS, 8'h08);
        acc(1'h1, OFS_CONTROL_STATUS, 8'h18);
        repeat (4) @(posedge ref_clk);
        acc(1'h1, OFS_CONTROL_STATUS, 8'h00);
        rd(OFS_CONTROL_STATUS, 8'h08);
        acc(1'h1, OFS_CONTROL_STATUS, 8'h18);
        acc(1'h1, OFS_CONTROL_STATUS, 8'h21);
        rd(OFS_CONTROL_STATUS, 8'h21);
        // restarts closer than one period keep the flag down
        acc(1'h1, OFS_RESTART, 8'h01);
        acc(1'h1, OFS_CONTROL_STATUS, 8'h18);
        acc(1'h1, OFS_CONTROL_STATUS, 8'h40);
        repeat (3) begin
            repeat (1500) @(posedge ref_clk);
            acc(1'h1, OFS_RESTART, 8'h01);
        end
        check(timeout_irq_flag, 1'h0);
        for (sel = 0; sel < 2; sel++) begin
            acc(1'h1, OFS_CONTROL_STATUS, 8'h18);
            // a flag left from the last period would end the first wait early
            acc(1'h1, OFS_CONTROL_STATUS, 8'hC0 | sel[7:0]);
            wait_for(1'h0);
            t0 = cyc;
            acc(1'h1, OFS_CONTROL_STATUS, 8'hC0 | sel[7:0]);
            wait_for(1'h0);
            check(cyc - t0, 32'h800 << sel);
        end
        rd(OFS_CONTROL_STATUS, 8'hC1);
        check(timeout_irq, 1'h0);
        global_irq_enable <= 1'h1;
        @(posedge ref_clk);
        check(timeout_irq, 1'h1);
        acc(1'h1, OFS_CONTROL_STATUS, 8'h41);
        rd(OFS_CONTROL_STATUS, 8'hC1);
        vector();
        rd(OFS_CONTROL_STATUS, 8'h41);
        global_irq_enable <= 1'h0;
        // combined mode: interrupt first, reset when left unserviced
        acc(1'h1, OFS_CONTROL_STATUS, 8'h18);
        acc(1'h1, OFS_CONTROL_STATUS, 8'h48);
        acc(1'h1, OFS_RESTART, 8'h01);
        wait_for(1'h0);
        rd(OFS_CONTROL_STATUS, 8'hC8);
        vector();
        rd(OFS_CONTROL_STATUS, 8'h08);
        acc(1'h1, OFS_CONTROL_STATUS, 8'h48);
        wait_for(1'h0);
        t0 = cyc;
        wait_for(1'h1);
        check(cyc - t0, 32'h800);
        rd(OFS_RESET_CAUSE, 8'h08);
        acc(1'h1, OFS_CONTROL_STATUS, 8'h18);
        acc(1'h1, OFS_CONTROL_STATUS, 8'h00);
        rd(OFS_CONTROL_STATUS, 8'h08);
        wait_for(1'h1);
        check(timeout_irq_flag, 1'h0);
        acc(1'h1, OFS_RESET_CAUSE, 8'h00);
        acc(1'h1, OFS_CONTROL_STATUS, 8'h18);
        acc(1'h1, OFS_CONTROL_STATUS, 8'h00);
        rd(OFS_CONTROL_STATUS, 8'h00);
        seen = 1'h0;
        repeat (2500) begin
            @(posedge ref_clk);
            seen = seen | system_reset_req | timeout_irq_flag;
        end
        check(seen, 1'h0);
        always_on_fuse <= 1'h1;
        acc(1'h1, OFS_CONTROL_STATUS, 8'h40);
        rd(OFS_CONTROL_STATUS, 8'h08);
        check(system_reset_enable, 1'h1);
        conclude();
    end
endmodule // tb
bind wdt_ctrl wdt_monitor wdt_monitor_i (.*);

/* testbench/wdt_monitor.sv */
// wdt_monitor: port-level checks of the watchdog control block
`timescale 1ns/1ps
module wdt_monitor
    import wdt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [wdt_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [wdt_pkg::BE_W-1:0] avs_byteenable,
    input wire logic [wdt_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [wdt_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic always_on_fuse,
    input wire logic global_irq_enable,
    input wire logic irq_vector_taken,
    input wire logic timeout_irq,
    input wire logic system_reset_req,
    input wire logic timeout_irq_flag,
    input wire logic system_reset_enable
);
    import wdt_pkg::*;
    logic req;
    logic w0;
    assign req = avs_read | avs_write;
    assign w0 = avs_write & !avs_waitrequest & avs_byteenable[0]
        & (avs_address == OFS_CONTROL_STATUS);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ****************************************************************
    // properties
    // ****************************************************************
    a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("no wait cycle on new request");
    a_wait_once: assert property (req && avs_waitrequest |=> !avs_waitrequest || !req)
        else $error("request not answered in one wait cycle");
    a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_irq_gated: assert property (timeout_irq |-> timeout_irq_flag && global_irq_enable)
        else $error("interrupt without flag and global enable");
    a_flag_w1c: assert property (w0 && avs_writedata[7] |=> !timeout_irq_flag)
        else $error("flag survives write of one");
    a_flag_w0: assert property (w0 && !avs_writedata[7] && timeout_irq_flag
        && !irq_vector_taken |=> timeout_irq_flag)
        else $error("flag lost on write of zero");
    a_vector_clear: assert property (irq_vector_taken |=> !timeout_irq_flag)
        else $error("flag kept after vector");
    a_fuse_lock: assert property (always_on_fuse && $past(always_on_fuse) && $past(rst_n)
        |-> system_reset_enable)
        else $error("reset enable low under fuse");
    a_reset_cause: assert property (system_reset_req |-> $past(system_reset_enable))
        else $error("reset without reset enable");
    a_reset_pulse: assert property (system_reset_req |=> !system_reset_req
        && system_reset_enable)
        else $error("reset pulse long or enable not held");
    cover property (system_reset_req);
    cover property (timeout_irq);
    cover property (irq_vector_taken && timeout_irq_flag);
endmodule // wdt_monitor
